// *** plq_cfg_regs.vh ***
`ifndef PLQ_CFG_REGS_VH
`define PLQ_CFG_REGS_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PLQ_IDX_RXFMT 16'h04A0
`define PLQ_IDX_POL 16'h0553
`define PLQ_IDX_LQCFG 16'h0560
`define PLQ_IDX_LQCNT 16'h0561
`define PLQ_IDX_LQSTAT 16'h0562

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PLQ_RST_RXFMT 16'h1000
`define PLQ_RST_POL 16'h0000
`define PLQ_RST_LQCFG 16'h07E4
`define PLQ_WMASK_RXFMT 16'hFFFD
`define PLQ_WMASK_POL 16'hFFFF
`define PLQ_WMASK_LQCFG 16'h3FFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLQ_SWAP_HI 15
`define PLQ_SWAP_LO 14
`define PLQ_SFD_BIT 13
`define PLQ_ENH_BIT 7
`define PLQ_POLEN_BIT 13
`define PLQ_POLVAL_BIT 12
`define PLQ_METRIC_HI 12
`define PLQ_METRIC_LO 11
`define PLQ_FMASK_HI 10
`define PLQ_FMASK_LO 5
`define PLQ_HYST_HI 4
`define PLQ_HYST_LO 3
`define PLQ_SQI_HI 2
`define PLQ_SQI_LO 0
`define PLQ_CREADY_BIT 15

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define PLQ_SWAP_NONE 2'h0
`define PLQ_SWAP_BITS 2'h1
`define PLQ_SWAP_NIB 2'h2
`define PLQ_SWAP_BITNIB 2'h3
`define PLQ_SFD_NORMAL 8'hD5
`define PLQ_SFD_ALT 8'h5D
`define PLQ_MET_STD 2'h0
`define PLQ_MET_MON 2'h1
`define PLQ_MET_SEND 2'h2
`define PLQ_MET_CREADY 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLQ_CLK_MHZ 40
`define PLQ_HYST_2MS_US 2000
`define PLQ_HYST_500US_US 500
`define PLQ_HYST_1MS_US 1000
`define PLQ_HYST_4MS_US 4000

`endif

// *** plq_rx_fmt.v ***
`timescale 1ns/1ps
`default_nettype none
`include "plq_cfg_regs.vh"

module plq_rx_fmt (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [1:0] swap_sel_i,
  input wire sfd_sel_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  output reg sfd_det_o
);

  // ----------------------------------------------------------------
  // byte reorder
  // ----------------------------------------------------------------
  function [3:0] rev4;
    input [3:0] n;
    begin
      rev4 = {n[0], n[1], n[2], n[3]};
    end
  endfunction

  reg [7:0] data_next;
  reg [7:0] sfd_pat;

  always @* begin
    case (swap_sel_i)
      `PLQ_SWAP_NONE: data_next = rx_data_i;
      `PLQ_SWAP_BITS: data_next = {rev4(rx_data_i[3:0]),
                                   rev4(rx_data_i[7:4])};
      `PLQ_SWAP_NIB: data_next = {rx_data_i[3:0], rx_data_i[7:4]};
      `PLQ_SWAP_BITNIB: data_next = {rev4(rx_data_i[7:4]),
                                     rev4(rx_data_i[3:0])};
      default: data_next = rx_data_i;
    endcase
    sfd_pat = sfd_sel_i ? `PLQ_SFD_ALT : `PLQ_SFD_NORMAL;
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      sfd_det_o <= 1'b0;
    end else begin
      rx_data_o <= data_next;
      rx_valid_o <= rx_valid_i;
      sfd_det_o <= rx_valid_i & (data_next == sfd_pat);
    end
  end

endmodule

`default_nettype wire

// *** plq_cfg_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "plq_cfg_regs.vh"

module plq_cfg_top #(
  parameter CNT_W = 18,
  parameter [CNT_W-1:0] HYST_2MS_CYC = `PLQ_HYST_2MS_US * `PLQ_CLK_MHZ,
  parameter [CNT_W-1:0] HYST_500US_CYC = `PLQ_HYST_500US_US * `PLQ_CLK_MHZ,
  parameter [CNT_W-1:0] HYST_1MS_CYC = `PLQ_HYST_1MS_US * `PLQ_CLK_MHZ,
  parameter [CNT_W-1:0] HYST_4MS_CYC = `PLQ_HYST_4MS_US * `PLQ_CLK_MHZ
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  output wire [7:0] rx_data_o,
  output wire rx_valid_o,
  output wire sfd_det_o,
  output reg enh_rx_en_o,
  input wire auto_pol_inv_i,
  output reg pol_inv_o,
  input wire link_up_std_i,
  input wire link_mon_i,
  input wire phy_send_data_i,
  input wire comm_cond_i,
  input wire [2:0] sqi_i,
  input wire [4:0] fail_cause_i,
  input wire link_loss_i,
  output reg link_up_o,
  output reg comm_ready_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] rxfmt_reg;
  reg [15:0] pol_reg;
  reg [15:0] lqcfg_reg;
  reg [9:0] fail_cnt_reg;
  reg [5:0] loss_cnt_reg;
  reg comm_ready_reg;
  reg [CNT_W-1:0] hyst_cnt_reg;
  reg sqi_bad_reg;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire [15:0] widx = {2'b00, paddr_i[15:2]};
  wire access = psel_i & penable_i & ~pready_o;
  wire wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  wire [15:0] wdata16 = {pstrb_i[1] ? pwdata_i[15:8] : 8'h00,
                         pstrb_i[0] ? pwdata_i[7:0] : 8'h00};
  wire [15:0] wlane = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  function [15:0] merge;
    input [15:0] old;
    input [15:0] wmask;
    input [15:0] lanes;
    input [15:0] data;
    begin
      merge = (old & ~(wmask & lanes)) | (data & wmask & lanes);
    end
  endfunction

  reg [15:0] rd_next;
  reg hit_next;

  always @* begin
    hit_next = 1'b1;
    case (widx)
      `PLQ_IDX_RXFMT: rd_next = rxfmt_reg;
      `PLQ_IDX_POL: rd_next = pol_reg;
      `PLQ_IDX_LQCFG: rd_next = lqcfg_reg;
      `PLQ_IDX_LQCNT: rd_next = {loss_cnt_reg, fail_cnt_reg};
      `PLQ_IDX_LQSTAT: rd_next = {comm_ready_reg, 15'h0000};
      default: begin
        rd_next = 16'h0000;
        hit_next = 1'b0;
      end
    endcase
    if (paddr_i[1:0] != 2'b00) begin
      rd_next = 16'h0000;
      hit_next = 1'b0;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= access;
      pslverr_o <= access & ~hit_next;
      if (access & ~pwrite_i) begin
        prdata_o <= {16'h0000, rd_next};
      end
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxfmt_reg <= `PLQ_RST_RXFMT;
      pol_reg <= `PLQ_RST_POL;
      lqcfg_reg <= `PLQ_RST_LQCFG;
    end else if (wr_en) begin
      if (widx == `PLQ_IDX_RXFMT) begin
        rxfmt_reg <= merge(rxfmt_reg, `PLQ_WMASK_RXFMT, wlane, wdata16);
      end
      if (widx == `PLQ_IDX_POL) begin
        pol_reg <= merge(pol_reg, `PLQ_WMASK_POL, wlane, wdata16);
      end
      if (widx == `PLQ_IDX_LQCFG) begin
        lqcfg_reg <= merge(lqcfg_reg, `PLQ_WMASK_LQCFG, wlane, wdata16);
      end
    end
  end

  // ----------------------------------------------------------------
  // receive formatting
  // ----------------------------------------------------------------
  plq_rx_fmt u_rx_fmt (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .swap_sel_i(rxfmt_reg[`PLQ_SWAP_HI:`PLQ_SWAP_LO]),
    .sfd_sel_i(rxfmt_reg[`PLQ_SFD_BIT]),
    .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i),
    .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o),
    .sfd_det_o(sfd_det_o)
  );

  // ----------------------------------------------------------------
  // polarity, enhanced features, link-up metric
  // ----------------------------------------------------------------
  wire [1:0] metric = lqcfg_reg[`PLQ_METRIC_HI:`PLQ_METRIC_LO];
  reg link_up_next;

  always @* begin
    case (metric)
      `PLQ_MET_STD: link_up_next = link_up_std_i;
      `PLQ_MET_MON: link_up_next = link_mon_i;
      `PLQ_MET_SEND: link_up_next = phy_send_data_i;
      `PLQ_MET_CREADY: link_up_next = comm_ready_reg;
      default: link_up_next = link_up_std_i;
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enh_rx_en_o <= 1'b0;
      pol_inv_o <= 1'b0;
      link_up_o <= 1'b0;
      comm_ready_o <= 1'b0;
    end else begin
      enh_rx_en_o <= rxfmt_reg[`PLQ_ENH_BIT];
      pol_inv_o <= pol_reg[`PLQ_POLEN_BIT] ?
                   pol_reg[`PLQ_POLVAL_BIT] :
                   auto_pol_inv_i;
      link_up_o <= link_up_next;
      comm_ready_o <= comm_ready_reg;
    end
  end

  // ----------------------------------------------------------------
  // comm-ready hysteresis
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] hyst_lim;
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  always @* begin
    case (lqcfg_reg[`PLQ_HYST_HI:`PLQ_HYST_LO])
      2'h0: hyst_lim = HYST_2MS_CYC;
      2'h1: hyst_lim = HYST_500US_CYC;
      2'h2: hyst_lim = HYST_1MS_CYC;
      2'h3: hyst_lim = HYST_4MS_CYC;
      default: hyst_lim = HYST_2MS_CYC;
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comm_ready_reg <= 1'b0;
      hyst_cnt_reg <= {CNT_W{1'b0}};
    end else if (comm_cond_i == comm_ready_reg) begin
      hyst_cnt_reg <= {CNT_W{1'b0}};
    end else if (hyst_cnt_reg + CNT_ONE >= hyst_lim) begin
      comm_ready_reg <= comm_cond_i;
      hyst_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      hyst_cnt_reg <= hyst_cnt_reg + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // link failure logging
  // ----------------------------------------------------------------
  wire sqi_bad = sqi_i > lqcfg_reg[`PLQ_SQI_HI:`PLQ_SQI_LO];
  wire [5:0] causes = {fail_cause_i, sqi_bad & ~sqi_bad_reg};
  wire [5:0] en_mask = lqcfg_reg[`PLQ_FMASK_HI:`PLQ_FMASK_LO];
  wire fail_inc = |(causes & en_mask) & ~link_loss_i;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sqi_bad_reg <= 1'b0;
      fail_cnt_reg <= 10'h000;
      loss_cnt_reg <= 6'h00;
    end else begin
      sqi_bad_reg <= sqi_bad;
      if (fail_inc && fail_cnt_reg != 10'h3FF) begin
        fail_cnt_reg <= fail_cnt_reg + 10'h001;
      end
      if (link_loss_i && loss_cnt_reg != 6'h3F) begin
        loss_cnt_reg <= loss_cnt_reg + 6'h01;
      end
    end
  end

endmodule

`default_nettype wire

// *** plq_cfg_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module plq_cfg_checker (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic sfd_det_o,
  input wire logic link_up_std_i,
  input wire logic link_mon_i,
  input wire logic phy_send_data_i,
  input wire logic comm_cond_i,
  input wire logic comm_ready_o,
  input wire logic link_up_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held two cycles");
  a_ready_wait: assert property
    (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no answer one cycle after access");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_swap_bits: assert property (
    rx_valid_o |-> $countones(rx_data_o) == $countones($past(rx_data_i)))
    else $error("reordered byte lost bits");
  a_sfd_match: assert property (
    sfd_det_o |-> rx_valid_o && (rx_data_o == 8'hD5 || rx_data_o == 8'h5D))
    else $error("delimiter flag on other byte");
  a_link_agree: assert property (
    (link_up_std_i && link_mon_i && phy_send_data_i) ##1 comm_ready_o
    |-> link_up_o) else $error("link up not from a source");
  a_cready_rise: assert property ($rose(comm_ready_o) |->
    $past(comm_cond_i, 2) && $past(comm_cond_i, 4) && $past(comm_cond_i, 6))
    else $error("comm ready rose too early");
  a_cready_fall: assert property ($fell(comm_ready_o) |->
    !$past(comm_cond_i, 2) && !$past(comm_cond_i, 4) &&
    !$past(comm_cond_i, 6))
    else $error("comm ready fell too early");
  c_sfd: cover property (sfd_det_o);
  c_cready: cover property ($rose(comm_ready_o));
  c_err: cover property (pslverr_o);
endmodule
`default_nettype wire

// *** plq_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module plq_mac_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic rx_valid_i,
  input wire logic sfd_det_i,
  input wire logic enh_rx_en_i,
  output logic [7:0] sfd_count_o
);
  // enhanced indications trusted only once enabled
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      sfd_count_o <= 8'h00;
    else if (rx_valid_i && sfd_det_i && enh_rx_en_i)
      sfd_count_o <= sfd_count_o + 8'h01;
  end
endmodule
`default_nettype wire

// *** plq_cfg_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "plq_cfg_regs.vh"
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module plq_cfg_tb_top;
  logic core_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, rx_valid_i = 0, auto_pol_inv_i = 0, link_loss_i = 0;
  logic link_up_std_i = 0, link_mon_i = 0, phy_send_data_i = 0;
  logic comm_cond_i = 0;
  logic [15:0] paddr_i = 0, v;
  logic [31:0] pwdata_i = 0;
  logic [3:0] pstrb_i = 4'h3;
  logic [7:0] rx_data_i = 0, b, x, dl;
  logic [2:0] sqi_i = 0, sq = 0, c;
  logic [4:0] fail_cause_i = 0;
  logic [5:0] msk;
  logic e;
  wire [31:0] prdata_o;
  wire [7:0] rx_data_o, sfd_count;
  wire pready_o, pslverr_o, rx_valid_o, sfd_det_o, enh_rx_en_o, pol_inv_o;
  wire link_up_o, comm_ready_o;
  int fail_count = 0, n_compared = 0, cyc = 0, seed = 34, ef = 0, el = 0;
  int nsfd = 0, n;
  localparam logic [15:0] A_RX = `PLQ_IDX_RXFMT * 4;
  localparam logic [15:0] A_POL = `PLQ_IDX_POL * 4;
  localparam logic [15:0] A_LQ = `PLQ_IDX_LQCFG * 4;
  localparam logic [15:0] A_CNT = `PLQ_IDX_LQCNT * 4;
  localparam logic [15:0] A_ST = `PLQ_IDX_LQSTAT * 4;
  plq_cfg_top #(.HYST_2MS_CYC(18'd20), .HYST_500US_CYC(18'd5),
    .HYST_1MS_CYC(18'd10), .HYST_4MS_CYC(18'd40)) dut (
    .core_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .rx_data_i,
    .rx_valid_i, .rx_data_o, .rx_valid_o, .sfd_det_o, .enh_rx_en_o,
    .auto_pol_inv_i, .pol_inv_o, .link_up_std_i, .link_mon_i,
    .phy_send_data_i, .comm_cond_i, .sqi_i, .fail_cause_i, .link_loss_i,
    .link_up_o, .comm_ready_o);
  plq_mac_model mac (.core_clk_i, .resetn_i, .rx_valid_i(rx_valid_o),
    .sfd_det_i(sfd_det_o), .enh_rx_en_i(enh_rx_en_o),
    .sfd_count_o(sfd_count));
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] sw(input logic [7:0] d, input logic [1:0] s);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = d[7-i];
    case (s)
      2'h0: return d;
      2'h1: return r;
      2'h2: return {d[3:0], d[7:4]};
      default: return {r[3:0], r[7:4]};
    endcase
  endfunction
  task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'($random(seed)), d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    v = prdata_o[15:0];
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] t);
    apb(1'b0, a, 16'h0000);
    `CHK("register", t, v);
  endtask
  task automatic pulse(input logic [4:0] f, input logic l,
    input logic [2:0] s);
    @(posedge core_clk_i);
    fail_cause_i <= f;
    link_loss_i <= l;
    sqi_i <= s;
    @(posedge core_clk_i);
    fail_cause_i <= 5'h00;
    link_loss_i <= 1'b0;
    if (|({f, s > 3'h4 && sq <= 3'h4} & msk) && !l) ef++;
    if (l) el++;
    sq = s;
    rd_chk(A_CNT, {el[5:0], ef[9:0]});
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd_chk(A_RX, 16'h1000);
    `CHK("enhanced", 1'b0, enh_rx_en_o);
    rd_chk(A_POL, 16'h0000);
    rd_chk(A_LQ, 16'h07E4);
    apb(1'b1, A_POL + 16'h0001, 16'hFFFF);
    `CHK("misaligned", 1'b1, e);
    apb(1'b0, 16'h1600, 16'h0000);
    `CHK("unmapped", 1'b1, e);
    rd_chk(A_POL, 16'h0000);
    apb(1'b1, A_RX, 16'hFFFF);
    rd_chk(A_RX, 16'hFFFD);
    apb(1'b1, A_LQ, 16'hFFFF);
    rd_chk(A_LQ, 16'h3FFF);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, A_RX, {k[2:1], k[0], 5'h10, 8'h80});
      dl = k[0] ? 8'h5D : 8'hD5;
      for (int j = 0; j < 6; j++) begin
        b = j < 2 ? sw(j ? ~dl ^ 8'h77 : dl, k[2:1]) : 8'($random(seed));
        @(posedge core_clk_i);
        rx_data_i <= b;
        rx_valid_i <= 1'b1;
        @(posedge core_clk_i);
        rx_valid_i <= 1'b0;
        @(negedge core_clk_i);
        x = sw(b, k[2:1]);
        nsfd += (x == dl);
        `CHK("rx byte", x, rx_data_o);
        `CHK("sfd", x == dl, sfd_det_o);
        `CHK("rx valid", 1'b1, rx_valid_o);
      end
    end
    @(negedge core_clk_i);
    `CHK("enhanced", 1'b1, enh_rx_en_o);
    `CHK("mac sfd", nsfd[7:0], sfd_count);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, A_POL, {2'h0, k[2:1], 12'h000});
      auto_pol_inv_i <= k[0];
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      `CHK("polarity", k[2] ? k[1] : k[0], pol_inv_o);
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_LQ, {3'h0, 2'(m), 11'h7E4});
      repeat (6) begin
        c = 3'($random(seed));
        @(posedge core_clk_i);
        {link_up_std_i, link_mon_i, phy_send_data_i} <= c;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        `CHK("link up", m == 3 ? 1'b0 : c[2-m], link_up_o);
      end
    end
    @(posedge core_clk_i);
    {link_up_std_i, link_mon_i, phy_send_data_i} <= 3'h7;
    msk = 6'h3F;
    apb(1'b1, A_LQ, 16'h07E4);
    for (int i = 0; i < 5; i++) pulse(5'h01 << i, 1'b0, 3'h0);
    pulse(5'h00, 1'b0, 3'h5);
    pulse(5'h00, 1'b0, 3'h5);
    pulse(5'h00, 1'b0, 3'h4);
    pulse(5'h02, 1'b1, 3'h7);
    repeat (12) begin
      msk = 6'($random(seed));
      apb(1'b1, A_LQ, {5'h00, msk, 5'h04});
      pulse(5'($random(seed)), 1'($random(seed)), 3'($random(seed)));
    end
    for (int s = 0; s < 4; s++) begin
      n = s == 0 ? 20 : s == 1 ? 5 : s == 2 ? 10 : 40;
      apb(1'b1, A_LQ, {3'h0, 2'h3, 6'h3F, 2'(s), 3'h4});
      comm_cond_i <= 1'b1;
      repeat (n - 1) @(posedge core_clk_i);
      comm_cond_i <= 1'b0;
      rd_chk(A_ST, 16'h0000);
      for (int p = 1; p >= 0; p--) begin
        comm_cond_i <= 1'(p);
        repeat (n + 1) @(posedge core_clk_i);
        rd_chk(A_ST, {1'(p), 15'h0000});
        `CHK("comm ready", 1'(p), comm_ready_o);
        `CHK("link up", 1'(p), link_up_o);
      end
    end
    close_out();
  end
endmodule
bind plq_cfg_top plq_cfg_checker u_chk (.core_clk_i, .resetn_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .rx_data_i, .rx_valid_i, .rx_data_o,
  .rx_valid_o, .sfd_det_o, .link_up_std_i, .link_mon_i, .phy_send_data_i,
  .comm_cond_i, .comm_ready_o, .link_up_o);
`default_nettype wire
